// *** verilog/cfg_memory_crc_checker.sv ***
// Purpose: background crc scan of configuration memory in user mode
// Assumes: memory answers mem_addr one cycle after it is presented
// Notes: error output holds until rst_n or a new configuration load
//
// Overview of operation
// - keeps rescanning whole memory while enabled and in user mode
// - no scanning unless enabled at load
// - error output raised on crc mismatch
// - divider sets check rate, 400 kHz-25 MHz (clk_sys)
// - reset then reload accepted as reconfiguration
module cfg_memory_crc_checker
	import cfg_crc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// configuration load from the loader
	input wire logic load_stb,
	input wire cfg_load_t load_data,
	input wire logic user_mode,
	// configuration memory read port
	output logic [ADDR_W-1:0] mem_addr,
	output logic mem_rd,
	input wire logic [DATA_W-1:0] mem_data,
	// status toward the system controller
	output logic crc_error,
	output logic pass_done
);
	// latched load-time settings
	cfg_load_t cfg_q;
	// sequencer
	scan_state_t state_q;
	scan_state_t state_d;
	// divider count and its tick
	logic [DIV_W-1:0] div_cnt_q;
	logic tick_q;
	// address and read strobe
	logic [ADDR_W-1:0] addr_q;
	logic rd_q;
	// sticky error and pass pulse
	logic err_q;
	logic pass_q;
	// accumulator view
	logic [CRC_W-1:0] crc_val;
	logic run;

	// clamp a divide setting into the legal check-rate window
	function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] v);
		if (v < DIV_MIN) begin
			return DIV_MIN;
		end else if (v > DIV_MAX) begin
			return DIV_MAX;
		end
		return v;
	endfunction : clamp_div

	// checking runs only when enabled and in user mode
	assign run = cfg_q.enable && user_mode;

	// capture settings at every configuration load
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfg_q <= '{enable: 1'b0, div_sel: DIV_RST, ref_crc: CRC_REF_RST};
		end else if (load_stb) begin
			// a reload after reset replaces everything
			cfg_q <= '{enable: load_data.enable,
				div_sel: clamp_div(load_data.div_sel),
				ref_crc: load_data.ref_crc};
		end
	end

	// check-rate divider: one tick every div_sel clocks
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !run) begin
			div_cnt_q <= DIV_RST;
			tick_q <= 1'b0;
		end else if (div_cnt_q <= DIV_MIN) begin
			div_cnt_q <= cfg_q.div_sel;
			tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q - DIV_MIN;
			tick_q <= 1'b0;
		end
	end

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				// restart at once, no request needed
				if (run) begin
					state_d = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (!run) begin
					state_d = ST_IDLE;
				end else if (tick_q) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// data for addr_q is present this cycle
				if (!run) begin
					state_d = ST_IDLE;
				end else if (addr_q == ADDR_LAST) begin
					state_d = ST_CMP;
				end else begin
					state_d = ST_SCAN;
				end
			end
			ST_CMP: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// state register; a load restarts the pass
	always_ff @(posedge clk_sys) begin
		if (!rst_n || load_stb) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// address walk and read strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n || load_stb) begin
			addr_q <= ADDR_RST;
			rd_q <= 1'b0;
		end else begin
			rd_q <= (state_q == ST_SCAN) && run && tick_q;
			if (state_q == ST_IDLE) begin
				addr_q <= ADDR_RST;
			end else if (state_q == ST_WAIT) begin
				// wraps to zero after the last word
				addr_q <= addr_q + 8'h01;
			end
		end
	end

	// crc engine: cleared at pass start, fed in the wait cycle
	crc_accum u_crc (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clear(state_q == ST_IDLE),
		.update(state_q == ST_WAIT && run),
		.data(mem_data),
		.crc_q(crc_val)
	);

	// sticky error; only rst_n or a reload clears it
	always_ff @(posedge clk_sys) begin
		if (!rst_n || load_stb) begin
			err_q <= 1'b0;
		end else if (state_q == ST_CMP && crc_val != cfg_q.ref_crc) begin
			err_q <= 1'b1;
		end
	end

	// one pulse per finished comparison
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pass_q <= 1'b0;
		end else begin
			pass_q <= (state_q == ST_CMP);
		end
	end

	assign mem_addr = addr_q;
	assign mem_rd = rd_q;
	assign crc_error = err_q;
	assign pass_done = pass_q;

	// error never drops without reset or reload
	a_error_sticky: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$fell(crc_error) |-> $past(load_stb))
		else $error("crc error dropped without reload");

	// error rises only after a mismatching comparison
	a_error_cause: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(crc_error) |-> $past(state_q == ST_CMP)
			&& $past(pass_done == 1'b0)
			&& $past(crc_val != cfg_q.ref_crc))
		else $error("crc error without mismatch");

	// mismatch at compare sets the error next cycle
	a_mismatch_flags: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_CMP && crc_val != cfg_q.ref_crc && !load_stb)
			|=> crc_error)
		else $error("mismatch not flagged");

	// disabled device never reads memory
	a_idle_disabled: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!cfg_q.enable |=> !mem_rd)
		else $error("read while disabled");

	// pass restarts through idle after compare while running, back in scan two cycles after compare
	a_rescan_start: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == ST_CMP && run && !load_stb) ##1 (run && !load_stb)
			|=> state_q == ST_SCAN)
		else $error("scan did not restart");

	// at the largest divide setting, no read in the 8 cycles after a read
	a_read_spacing: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(mem_rd && cfg_q.div_sel == DIV_MAX && !load_stb)
			|=> !mem_rd [*8])
		else $error("reads faster than divider");

	// reload restarts the sequencer from idle
	a_reload_idle: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		load_stb |=> state_q == ST_IDLE && !crc_error
			&& mem_addr == ADDR_RST)
		else $error("reload not accepted");
endmodule : cfg_memory_crc_checker

// *** verilog/cfg_crc_pkg.sv ***
// Purpose: shared constants and types for the config memory crc checker
// Assumes: single 25 MHz system clock, config memory read with 1 cycle latency
// Notes: check rate is clk_sys divided by a setting latched at load time
package cfg_crc_pkg;
	// system clock, in kHz
	localparam int CLK_KHZ = 25000;
	// slowest and fastest check clock, in kHz
	localparam int CHK_MIN_KHZ = 400;
	localparam int CHK_MAX_KHZ = 100000;
	// longest divide rounds down; fastest cannot beat clk_sys, so floor at 1
	localparam int DIV_MAX_INT = CLK_KHZ / CHK_MIN_KHZ;
	localparam int DIV_MIN_INT = (CLK_KHZ / CHK_MAX_KHZ) < 1 ? 1 :
		(CLK_KHZ / CHK_MAX_KHZ);
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] DIV_MAX = DIV_MAX_INT[DIV_W-1:0];
	localparam logic [DIV_W-1:0] DIV_MIN = DIV_MIN_INT[DIV_W-1:0];
	localparam logic [DIV_W-1:0] DIV_RST = DIV_MAX_INT[DIV_W-1:0];
	// configuration memory geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 8'hFF;
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
	// crc definition
	localparam int CRC_W = 32;
	localparam logic [CRC_W-1:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [CRC_W-1:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [CRC_W-1:0] CRC_REF_RST = 32'h00000000;

	// load-time settings delivered with the configuration data
	typedef struct packed {
		logic enable;
		logic [DIV_W-1:0] div_sel;
		logic [CRC_W-1:0] ref_crc;
	} cfg_load_t;

	// scan sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCAN = 2'b01,
		ST_WAIT = 2'b10,
		ST_CMP = 2'b11
	} scan_state_t;
endpackage : cfg_crc_pkg

// *** verilog/crc_accum.sv ***
// Purpose: crc accumulator folding one memory word per update
// Assumes: clear and update never in the same cycle (clear wins)
// Notes: msb-first, non-reflected, no final xor
module crc_accum
	import cfg_crc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic clear,
	input wire logic update,
	input wire logic [DATA_W-1:0] data,
	// running value
	output logic [CRC_W-1:0] crc_q
);
	// one word folded into the crc, bit by bit
	function automatic logic [CRC_W-1:0] crc_step(
		input logic [CRC_W-1:0] c,
		input logic [DATA_W-1:0] d
	);
		logic [CRC_W-1:0] r;
		r = c;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			if (r[CRC_W-1] ^ d[i]) begin
				r = {r[CRC_W-2:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[CRC_W-2:0], 1'b0};
			end
		end
		return r;
	endfunction : crc_step

	// accumulator register
	always_ff @(posedge clk_sys) begin
		if (!rst_n || clear) begin
			crc_q <= CRC_INIT;
		end else if (update) begin
			crc_q <= crc_step(crc_q, data);
		end
	end
endmodule : crc_accum

// *** tb/cfg_mem_model.sv ***
// Purpose: behavioural config memory feeding the crc scanner
// Assumes: word for the address of the cycle before stands with mem_rd
// Notes: outside mem_rd the bus shows the inverse, so a late sample fails
module cfg_mem_model
	import cfg_crc_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// read port from the scanner
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_rd,
	output logic [DATA_W-1:0] mem_data,
	// upset injection, flips bit 0 of one word
	input wire logic upset,
	input wire logic [ADDR_W-1:0] upset_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic flip; // one bit of injected corruption
	assign flip = upset && (mem_addr == upset_addr);
	logic [DATA_W-1:0] word_q = '0; // word fetched for the last address
	// fetch the word for the address seen at each edge
	always @(posedge clk_sys) begin
		word_q <= {mem_addr, ~mem_addr} ^ {15'h0000, flip};
	end
	// word only stands while the strobe does; otherwise inverted
	assign mem_data = mem_rd ? word_q : ~word_q;
endmodule : cfg_mem_model

// *** tb/cfg_memory_crc_checker_test.sv ***
// Purpose: self-checking bench for the config memory crc checker
// Assumes: inputs change 1 ns after the rising edge
// Notes: the bench plays loader and system controller
module cfg_memory_crc_checker_test
	import cfg_crc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0; // 25 MHz
	logic rst_n = 1'b0; // held low for 5 cycles
	logic load_stb = 1'b0;
	cfg_load_t load_data = '0;
	logic user_mode = 1'b1;
	logic upset = 1'b0;
	logic [ADDR_W-1:0] upset_addr = 8'h80;
	logic [ADDR_W-1:0] mem_addr;
	logic mem_rd;
	logic [DATA_W-1:0] mem_data;
	logic crc_error;
	logic pass_done;
	int fail_count = 0;
	int checks_done = 0;
	int rd_cnt = 0; // total reads since start, never cleared
	int cyc_no = 0;
	int rd_last = 0;
	int rd_gap = 0; // cycles between the last two reads
	int rd_base = 0; // rd_cnt at the last clear
	int addr_skips = 0; // reads that broke the ascending walk
	logic [ADDR_W-1:0] rd_addr = 8'h00; // address of the latest read
	logic [CRC_W-1:0] good; // reference a loader would compute
	cfg_memory_crc_checker uut (.clk_sys(clk_sys), .rst_n(rst_n),
		.load_stb(load_stb), .load_data(load_data), .user_mode(user_mode),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data),
		.crc_error(crc_error), .pass_done(pass_done));
	cfg_mem_model mem (.clk_sys(clk_sys), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_data(mem_data), .upset(upset),
		.upset_addr(upset_addr));
	initial forever #20 clk_sys = ~clk_sys;
	// read bookkeeping
	always @(posedge clk_sys) begin
		cyc_no <= cyc_no + 1;
		if (mem_rd === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
			rd_gap <= cyc_no - rd_last;
			rd_last <= cyc_no;
			rd_addr <= mem_addr;
			// reads climb by one, or restart at zero
			if (mem_addr !== rd_addr + 8'h01 && mem_addr !== 8'h00)
				addr_skips <= addr_skips + 1;
		end
	end
	// crc of the clean image, msb first, no reflection
	function automatic logic [CRC_W-1:0] image_crc();
		logic [CRC_W-1:0] c;
		logic [15:0] w;
		c = CRC_INIT;
		for (int a = 0; a < 256; a++) begin
			w = {a[7:0], ~a[7:0]};
			for (int b = 15; b >= 0; b--)
				c = {c[30:0], 1'b0} ^ ((c[31] ^ w[b]) ? CRC_POLY : 32'h0);
		end
		return c;
	endfunction : image_crc
	task chk(input string what, input logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task conclude;
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task load(input logic en, input logic [5:0] d);
		load_stb = 1'b1;
		load_data = {en, d, good};
		cyc(1);
		load_stb = 1'b0;
		rd_base = rd_cnt;
	endtask : load
	task wait_pass;
		int i;
		i = 0;
		do begin
			cyc(1);
			i++;
		end while (pass_done !== 1'b1 && i < 3000);
		chk("pass_done", 1, pass_done);
	endtask : wait_pass
	task t_off;
		load(1'b0, 6'h01);
		cyc(1500);
		chk("reads while off", 0, rd_cnt - rd_base);
		chk("crc_error off", 0, crc_error);
	endtask : t_off
	task t_clean;
		load(1'b1, 6'h01);
		wait_pass();
		chk("reads in pass", 256, rd_cnt - rd_base);
		chk("last read address", 8'hFF, rd_addr);
		chk("crc_error clean", 0, crc_error);
		wait_pass();
		chk("reads in two passes", 512, rd_cnt - rd_base);
		chk("address skips", 0, addr_skips);
	endtask : t_clean
	task t_upset;
		upset = 1'b1;
		load(1'b1, 6'h01);
		wait_pass();
		chk("crc_error upset", 1, crc_error);
		wait_pass();
		chk("crc_error held", 1, crc_error);
		load(1'b1, 6'h01);
		chk("crc_error after load", 0, crc_error);
		wait_pass();
		chk("crc_error before reset", 1, crc_error);
		rst_n = 1'b0; // controller reacts to the error
		cyc(2);
		chk("crc_error in reset", 0, crc_error);
		rst_n = 1'b1;
		upset = 1'b0;
		load(1'b1, 6'h01);
		wait_pass();
		chk("crc_error reloaded", 0, crc_error);
	endtask : t_upset
	task automatic t_rate;
		logic [5:0] d[4] = '{6'h00, 6'h01, 6'h3E, 6'h3F};
		int lo[4] = '{1, 1, 62, 62};
		for (int k = 0; k < 4; k++) begin
			load(1'b1, d[k]);
			cyc(300);
			chk("read gap", 1, rd_gap >= lo[k] && rd_gap <= lo[k] + 3);
		end
		user_mode = 1'b0;
		cyc(3);
		rd_base = rd_cnt;
		cyc(300);
		chk("reads out of user mode", 0, rd_cnt - rd_base);
		user_mode = 1'b1;
	endtask : t_rate
	initial begin
		good = image_crc();
		cyc(5);
		rst_n = 1'b1;
		t_off();
		t_clean();
		t_upset();
		t_rate();
		conclude();
	end
	// watchdog, about three times the expected run
	initial begin
		#(20000 * 40);
		fail_count++;
		$display("unexpected watchdog: expected finish, seen timeout");
		conclude();
	end
endmodule : cfg_memory_crc_checker_test
